/* File: hdl/spindle_sync_phase_control.sv */
// Purpose: spindle synchronisation, phase alignment, phase shift capture, error cancel
// Assumes: spindle positions and speed complete come from the drives each cycle
// Notes: registers over AXI4-Lite; one write and one read at a time
`timescale 1ns/100ps
module spindle_sync_phase_control (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // spindle drive side
   input wire logic [7:0] connected_mask,
   input wire logic speed_sync_complete_flag,
   input wire logic chuck_closed_confirm,
   input wire logic [spindle_sync_pkg::POS_W-1:0] basic_position,
   input wire logic [spindle_sync_pkg::POS_W-1:0] sync_position,
   input wire logic [spindle_sync_pkg::PHASE_W-1:0] phase_error,
   // controls to the drives
   output logic sync_mode_active_flag,
   output logic phase_sync_complete_flag,
   output logic sync_reverse,
   output logic phase_align_enable,
   output logic [spindle_sync_pkg::PHASE_W-1:0] phase_target,
   output logic handwheel_inhibit,
   output logic chuck_close_command,
   output logic error_cancel_active,
   output logic [spindle_sync_pkg::POS_W-1:0] position_correction,
   output logic [2:0] basic_spindle,
   output logic [2:0] sync_spindle
);
   import spindle_sync_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [9:0] ctrl;
      logic [2:0] basic_select;
      logic [2:0] sync_select;
      logic [15:0] level;
      logic [PHASE_W-1:0] phase_cmd;
      logic [PHASE_W-1:0] stored_phase;
      logic captured;
      logic [POS_W-1:0] cancel_diff;
      logic cancel_prev;
      logic mode;
      phase_state_t phase_state;
      logic phase_done;
      logic [PHASE_W-1:0] target;
   } state_t;

   state_t st;
   state_t next_st;
   logic select_valid;
   logic [2:0] basic_sel_q;
   logic [2:0] sync_sel_q;

   assign basic_sel_q = st.basic_select;
   assign sync_sel_q = st.sync_select;

   spindle_sync_select u_select (
      .basic_select(basic_sel_q),
      .sync_select(sync_sel_q),
      .connected_mask(connected_mask),
      .basic_spindle(basic_spindle),
      .sync_spindle(sync_spindle),
      .select_valid(select_valid)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic [PHASE_W-1:0] abs_err;
   assign abs_err = phase_error[PHASE_W-1] ? PHASE_W'(-phase_error) : phase_error;

   always_comb begin
      logic [31:0] cur;
      logic [31:0] upd;
      logic wr_go;
      logic rd_go;
      logic cancel_req;
      logic phase_req;
      logic capture_req;
      logic offset_req;
      logic cancel_hold;
      logic phase_arg;
      cur = 32'h0000_0000;
      upd = 32'h0000_0000;
      wr_go = 1'b0;
      rd_go = 1'b0;
      cancel_req = 1'b0;
      phase_req = 1'b0;
      capture_req = 1'b0;
      offset_req = 1'b0;
      cancel_hold = 1'b0;
      phase_arg = 1'b0;
      next_st = st;
      // write channel: address and data taken in either order
      if (s_axi_awvalid && !st.aw_held && !st.bvalid) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_held && !st.bvalid) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      wr_go = st.aw_held && st.w_held && !st.bvalid;
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         unique case (st.aw_addr)
            CTRL_OFS: begin
               upd = merge({22'h0, st.ctrl}, st.w_data, st.w_strb);
               next_st.ctrl = upd[9:0];
            end
            SEL_OFS: begin
               upd = merge({21'h0, st.sync_select, 5'h0, st.basic_select}, st.w_data, st.w_strb);
               next_st.basic_select = upd[2:0];
               next_st.sync_select = upd[10:8];
            end
            LEVEL_OFS: begin
               upd = merge({16'h0, st.level}, st.w_data, st.w_strb);
               next_st.level = upd[15:0];
            end
            PHASE_CMD_OFS: begin
               upd = merge({16'h0, st.phase_cmd}, st.w_data, st.w_strb);
               next_st.phase_cmd = upd[PHASE_W-1:0];
            end
            STATUS_OFS, STORED_OFS, CANCEL_DIFF_OFS, PHASE_ERR_OFS: begin
               next_st.bresp = RESP_OKAY;
            end
            default: begin
               next_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // read channel
      rd_go = s_axi_arvalid && !st.rvalid;
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            CTRL_OFS: cur = {22'h0, st.ctrl};
            SEL_OFS: cur = {21'h0, st.sync_select, 5'h0, st.basic_select};
            LEVEL_OFS: cur = {16'h0, st.level};
            PHASE_CMD_OFS: cur = {16'h0, st.phase_cmd};
            STATUS_OFS: begin
               cur = 32'h0000_0000;
               cur[STAT_MODE] = st.mode;
               cur[STAT_SPEED] = speed_sync_complete_flag;
               cur[STAT_PHASE] = st.phase_done;
               cur[STAT_CHUCK] = chuck_closed_confirm;
               cur[STAT_CAPTURED] = st.captured;
               cur[STAT_ALIGNING] = (st.phase_state == PH_ALIGN);
               cur[STAT_CANCELING] = st.cancel_prev;
               cur[STAT_INHIBIT] = st.ctrl[CTRL_CAPTURE] && st.ctrl[CTRL_HANDWHEEL];
            end
            STORED_OFS: cur = {16'h0, st.stored_phase};
            CANCEL_DIFF_OFS: cur = st.cancel_diff;
            PHASE_ERR_OFS: cur = {16'h0, phase_error};
            default: begin
               cur = 32'h0000_0000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
         next_st.rdata = cur;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      cancel_req = st.ctrl[CTRL_CANCEL];
      phase_req = st.ctrl[CTRL_PHASE];
      capture_req = st.ctrl[CTRL_CAPTURE];
      offset_req = st.ctrl[CTRL_OFFSET];
      cancel_hold = st.ctrl[CTRL_CANCEL_HOLD];
      phase_arg = st.ctrl[CTRL_PHASE_ARG];

      // synchronous mode follows the request while selection is legal and the cancel bit is clear
      next_st.mode = st.ctrl[CTRL_SYNC] && !cancel_req && select_valid;

      // phase shift capture once speed sync completes, no phase argument
      if (capture_req && !phase_arg && st.mode && speed_sync_complete_flag) begin
         next_st.stored_phase = phase_error;
         next_st.captured = 1'b1;
      end

      // error cancel: latch difference on the rising edge
      next_st.cancel_prev = cancel_hold;
      if (cancel_hold && !st.cancel_prev) begin
         next_st.cancel_diff = POS_W'(basic_position - sync_position);
      end

      // phase alignment state machine
      unique case (st.phase_state)
         PH_IDLE: begin
            next_st.phase_done = 1'b0;
            if (st.mode && phase_req && !capture_req) begin
               next_st.phase_state = PH_ALIGN;
               // offset mode adds the commanded phase to the stored error
               next_st.target = (offset_req && phase_arg)
                  ? PHASE_W'(st.stored_phase + st.phase_cmd)
                  : st.phase_cmd;
            end
         end
         PH_ALIGN: begin
            if (!st.mode || !phase_req || capture_req) begin
               next_st.phase_state = PH_IDLE;
            end else if (abs_err <= st.level) begin
               next_st.phase_state = PH_DONE;
               next_st.phase_done = 1'b1;
            end
         end
         PH_DONE: begin
            if (!st.mode || !phase_req || capture_req) begin
               next_st.phase_state = PH_IDLE;
               next_st.phase_done = 1'b0;
            end
         end
         default: begin
            next_st.phase_state = PH_IDLE;
            next_st.phase_done = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
         st.ctrl <= CTRL_RESET;
         st.basic_select <= SEL_RESET;
         st.sync_select <= SEL_RESET;
         st.level <= LEVEL_RESET;
         st.phase_state <= PH_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // bus handshakes
   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready = !st.w_held && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // drive side outputs
   assign sync_mode_active_flag = st.mode;
   assign phase_sync_complete_flag = st.phase_done;
   assign sync_reverse = st.ctrl[CTRL_DIR];
   assign phase_align_enable = (st.phase_state != PH_IDLE);
   assign phase_target = st.target;
   assign handwheel_inhibit = st.ctrl[CTRL_CAPTURE] && st.ctrl[CTRL_HANDWHEEL];
   // chuck close is its own bit so cancel can outlive it
   assign chuck_close_command = st.ctrl[CTRL_CHUCK];
   assign error_cancel_active = st.cancel_prev;
   assign position_correction = st.cancel_prev ? st.cancel_diff : '0;
endmodule // spindle_sync_phase_control

/* File: pkg/spindle_sync_pkg.sv */
// Purpose: constants and types for the spindle synchronisation phase control block
// Assumes: 125 MHz clock, AXI4-Lite register access, 32-bit data
// Notes: offsets and bit positions are local choices
// Summary of operation
// - sync mode request enters synchronous control mode
// - no sync if unconnected or same spindle
// - phase request in sync mode starts alignment
// - phase complete when error within attainment level
// - phase request ignored outside sync mode
// - direction bit: 0 same, 1 reverse
// - capture phase error on speed sync complete
// - no phase alignment during phase capture
// - handwheel rotation blocked during phase capture
// - offset request with phase argument aligns to stored plus commanded
// - cancel rising edge captures position difference
// - while cancel held, subtract captured difference
package spindle_sync_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SEL_OFS = 8'h04;
   localparam logic [7:0] LEVEL_OFS = 8'h08;
   localparam logic [7:0] PHASE_CMD_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] STORED_OFS = 8'h14;
   localparam logic [7:0] CANCEL_DIFF_OFS = 8'h18;
   localparam logic [7:0] PHASE_ERR_OFS = 8'h1C;
   // control bit positions
   localparam int CTRL_SYNC = 0;
   localparam int CTRL_CANCEL = 1;
   localparam int CTRL_PHASE = 2;
   localparam int CTRL_DIR = 3;
   localparam int CTRL_CAPTURE = 4;
   localparam int CTRL_OFFSET = 5;
   localparam int CTRL_CANCEL_HOLD = 6;
   localparam int CTRL_PHASE_ARG = 7;
   localparam int CTRL_HANDWHEEL = 8;
   localparam int CTRL_CHUCK = 9;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   // status bit positions
   localparam int STAT_MODE = 0;
   localparam int STAT_SPEED = 1;
   localparam int STAT_PHASE = 2;
   localparam int STAT_CHUCK = 3;
   localparam int STAT_CAPTURED = 4;
   localparam int STAT_ALIGNING = 5;
   localparam int STAT_CANCELING = 6;
   localparam int STAT_INHIBIT = 7;
   // spindle selects, 0 means default
   localparam logic [2:0] SEL_DEFAULT_BASIC = 3'h1;
   localparam logic [2:0] SEL_DEFAULT_SYNC = 3'h2;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic [15:0] LEVEL_RESET = 16'h0010;
   localparam int PHASE_W = 16;
   localparam int POS_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ALIGN = 2'b01,
      PH_DONE = 2'b11
   } phase_state_t;
endpackage

/* File: hdl/spindle_sync_select.sv */
// Purpose: resolves spindle selects and judges whether synchronisation may run
// Assumes: selects are 0..7, connected mask marks serial spindles
// Notes: purely combinational
`timescale 1ns/100ps
module spindle_sync_select (
   // selects
   input wire logic [2:0] basic_select,
   input wire logic [2:0] sync_select,
   input wire logic [7:0] connected_mask,
   // results
   output logic [2:0] basic_spindle,
   output logic [2:0] sync_spindle,
   output logic select_valid
);
   import spindle_sync_pkg::*;
   always_comb begin
      // zero picks the default spindle
      basic_spindle = (basic_select == 3'h0) ? SEL_DEFAULT_BASIC : basic_select;
      sync_spindle = (sync_select == 3'h0) ? SEL_DEFAULT_SYNC : sync_select;
      select_valid = connected_mask[basic_spindle] && connected_mask[sync_spindle]
         && (basic_spindle != sync_spindle);
   end
endmodule // spindle_sync_select

/* File: testbench/spindle_sync_properties.sv */
// Purpose: port-level checks for the spindle phase control block
// Assumes: attainment level stays at its reset value
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module spindle_sync_properties (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // watched ports
   input wire logic [spindle_sync_pkg::PHASE_W-1:0] phase_error,
   input wire logic sync_mode_active_flag,
   input wire logic phase_sync_complete_flag,
   input wire logic phase_align_enable,
   input wire logic handwheel_inhibit,
   input wire logic chuck_close_command,
   input wire logic error_cancel_active,
   input wire logic [spindle_sync_pkg::POS_W-1:0] position_correction,
   input wire logic [2:0] basic_spindle,
   input wire logic [2:0] sync_spindle
);
   import spindle_sync_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   mode_drop_clears_a: assert property (
      !sync_mode_active_flag |=> !phase_sync_complete_flag)
      else $error("phase complete kept after mode dropped");
   done_needs_align_a: assert property (
      phase_sync_complete_flag |-> phase_align_enable)
      else $error("phase complete without alignment");
   done_level_a: assert property (
      $rose(phase_sync_complete_flag) |-> $past(phase_error) <= LEVEL_RESET)
      else $error("phase complete before error within level");
   align_in_mode_a: assert property (
      $rose(phase_align_enable) |-> $past(sync_mode_active_flag))
      else $error("alignment started outside sync mode");
   capture_blocks_a: assert property (
      handwheel_inhibit |=> !phase_align_enable)
      else $error("alignment during phase capture");
   chuck_indep_a: assert property (
      $changed(chuck_close_command) && error_cancel_active |=> error_cancel_active)
      else $error("chuck change ended error cancel");
   chuck_first_a: assert property (
      $rose(error_cancel_active) |-> $past(chuck_close_command))
      else $error("error cancel raised before chuck close");
   corr_zero_a: assert property (
      !error_cancel_active |-> position_correction == '0)
      else $error("correction applied while cancel inactive");
   corr_hold_a: assert property (
      error_cancel_active && $past(error_cancel_active) |-> $stable(position_correction))
      else $error("captured difference changed during cancel");
   distinct_sel_a: assert property (
      sync_mode_active_flag |-> basic_spindle != sync_spindle)
      else $error("sync mode with identical spindles");
endmodule // spindle_sync_properties
bind spindle_sync_phase_control spindle_sync_properties checker_i (.clock, .arst_n, .phase_error,
   .sync_mode_active_flag, .phase_sync_complete_flag, .phase_align_enable, .handwheel_inhibit,
   .chuck_close_command, .error_cancel_active, .position_correction, .basic_spindle, .sync_spindle);

/* File: testbench/spindle_drive_model.sv */
// Purpose: behavioural spindle drives facing the phase control block
// Assumes: spindles 1 and 2 serially connected, others absent
// Notes: phase error closes in steps of two while alignment runs
`timescale 1ns/100ps
module spindle_drive_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // commands from the block
   input wire logic sync_mode_active_flag,
   input wire logic phase_align_enable,
   input wire logic chuck_close_command,
   input wire logic [31:0] ofs,
   // drive feedback
   output logic [7:0] connected_mask,
   output logic speed_sync_complete_flag,
   output logic chuck_closed_confirm,
   output logic [31:0] basic_position,
   output logic [31:0] sync_position,
   output logic [15:0] phase_error
);
   logic [2:0] ramp;
   assign connected_mask = 8'h06;
   assign sync_position = basic_position - ofs;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ramp <= 3'h0;
         speed_sync_complete_flag <= 1'b0;
         chuck_closed_confirm <= 1'b0;
         basic_position <= 32'h0;
         phase_error <= 16'h0123;
      end else begin
         basic_position <= basic_position + 32'h3;
         chuck_closed_confirm <= chuck_close_command;
         ramp <= sync_mode_active_flag ? ramp + {2'h0, ramp != 3'h7} : 3'h0;
         speed_sync_complete_flag <= sync_mode_active_flag && ramp == 3'h7;
         if (!phase_align_enable) phase_error <= 16'h0123;
         else if (phase_error > 16'h2) phase_error <= phase_error - 16'h2;
      end
   end
endmodule // spindle_drive_model

/* File: testbench/spindle_sync_phase_control_tb.sv */
// Purpose: self-checking bench for the spindle phase control block
// Assumes: drive model on the far side, attainment level left at reset
// Notes: reads and pin probes are queued and judged by one monitor
`timescale 1ns/100ps
module spindle_sync_phase_control_tb;
   import spindle_sync_pkg::*;
   logic clock, arst_n, probe;
   logic [7:0] s_axi_awaddr, s_axi_araddr, connected_mask;
   logic [31:0] s_axi_wdata, s_axi_rdata, basic_position, sync_position, position_correction, ofs;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, speed_sync_complete_flag;
   logic chuck_closed_confirm, sync_mode_active_flag, phase_sync_complete_flag, sync_reverse;
   logic phase_align_enable, handwheel_inhibit, chuck_close_command, error_cancel_active;
   logic [15:0] phase_error, phase_target, ph;
   logic [2:0] basic_spindle, sync_spindle;
   logic [33:0] probe_val;
   logic [67:0] q[$];
   int fails, n_tests, seed, t, n, i;
   spindle_sync_phase_control dut (.*);
   spindle_drive_model drives (.*);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task check(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock) begin
      logic [67:0] e;
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready) || probe) begin
         e = q.pop_front();
         if (probe) check(probe_val & e[67:34], e[33:0]);
         else if (s_axi_rready) check({s_axi_rresp, s_axi_rdata} & e[67:34], e[33:0]);
         else check({s_axi_bresp, 32'h0} & e[67:34], e[33:0]);
      end
   end
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      q.push_back({2'h3, m, ((a > PHASE_ERR_OFS) ? RESP_SLVERR : RESP_OKAY), e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      if (n == 100) fails++;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      q.push_back({2'h3, 32'h0, ((a > PHASE_ERR_OFS) ? RESP_SLVERR : RESP_OKAY), 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      if (n == 100) fails++;
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task probe_pin(input logic [31:0] v, input logic [31:0] e);
      q.push_back({34'h0FFFFFFFF, 2'h0, e});
      probe_val <= {2'h0, v};
      probe <= 1'b1;
      @(posedge clock);
      probe <= 1'b0;
      @(posedge clock);
   endtask
   task await(input logic sel);
      n = 0;
      while ((sel ? phase_sync_complete_flag : speed_sync_complete_flag) !== 1'b1 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      if (n == 1000) fails++;
   endtask
   task endt;
      t++;
      $display("test %0d done", t);
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, probe} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, probe_val} = '0;
      s_axi_wstrb = 4'hF;
      arst_n = 1'b0;
      seed = 34264;
      ofs = $random(seed);
      ph = 16'($random(seed));
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rd(CTRL_OFS, 32'hFFFFFFFF, 32'h0);
      rd(LEVEL_OFS, 32'hFFFF, {16'h0, LEVEL_RESET});
      rd(8'h40, 32'hFFFFFFFF, 32'h0);
      wr(8'h40, 32'h0);
      for (i = 0; i < 3; i++) begin
         wr(SEL_OFS, (i == 2) ? 32'h0 : 32'h0101 + 32'h2 * i);
         wr(CTRL_OFS, 32'h1);
         rd(STATUS_OFS, 32'h1, (i == 2));
      end
      probe_pin({sync_spindle, basic_spindle}, {SEL_DEFAULT_SYNC, SEL_DEFAULT_BASIC});
      endt;
      wr(CTRL_OFS, 32'h4);
      rd(STATUS_OFS, 32'h25, 32'h0);
      for (i = 0; i < 2; i++) begin
         wr(CTRL_OFS, 32'h1 | (i << 3));
         probe_pin(sync_reverse, i);
      end
      endt;
      wr(CTRL_OFS, 32'h10);
      wr(CTRL_OFS, 32'h11);
      await(1'b0);
      rd(STORED_OFS, 32'hFFFF, 32'h0123);
      wr(CTRL_OFS, 32'h115);
      rd(STATUS_OFS, 32'hA0, 32'h80);
      endt;
      wr(PHASE_CMD_OFS, {16'h0, ph});
      for (i = 0; i < 2; i++) begin
         wr(CTRL_OFS, 32'h1);
         wr(CTRL_OFS, 32'h85 | (i << 5));
         probe_pin(phase_target, 16'(ph + (i ? 16'h0123 : 16'h0)));
      end
      rd(STATUS_OFS, 32'h24, 32'h20);
      await(1'b1);
      rd(STATUS_OFS, 32'h4, 32'h4);
      wr(CTRL_OFS, 32'h1);
      rd(STATUS_OFS, 32'h4, 32'h0);
      wr(CTRL_OFS, 32'h5);
      await(1'b1);
      wr(CTRL_OFS, 32'h115);
      rd(STATUS_OFS, 32'h24, 32'h0);
      endt;
      wr(CTRL_OFS, 32'h201);
      rd(STATUS_OFS, 32'h8, 32'h8);
      wr(CTRL_OFS, 32'h241);
      probe_pin(position_correction, ofs);
      rd(STATUS_OFS, 32'h48, 32'h48);
      wr(CTRL_OFS, 32'h41);
      rd(STATUS_OFS, 32'h48, 32'h40);
      probe_pin(position_correction, ofs);
      wr(CTRL_OFS, 32'h1);
      probe_pin(position_correction, 32'h0);
      wr(CTRL_OFS, 32'h3);
      rd(STATUS_OFS, 32'h1, 32'h0);
      endt;
      report_and_stop;
   end
   initial begin
      #200000;
      fails++;
      report_and_stop;
   end
endmodule // spindle_sync_phase_control_tb
